// ---- hw/rail_fault_supervisor_params.svh ----
// constants for the rail fault supervisor: timing, comparator scaling, state codes
// assumes a 25 MHz mclk; times are in ns and the cycle counts derive from them
//
// Summary of operation
// - one shared power-ok output covers core and auxiliary rails together
// - power-ok low while off or soft-starting; released only after good soft-start
// - power-ok low on overvoltage, undervoltage, overcurrent, power-on reset or enable low
// - any protection fault latches the supervisor off with power-ok low
// - non-overvoltage latch clears on enable or supply toggle, then soft-start restarts
// - after overvoltage only a supply drop below power-on reset permits restart
// - core overcurrent when sense times five exceeds threshold input divided by six
// - core overcurrent acted on only after persisting 100us continuously
// - short circuit at 2.25 times overcurrent threshold trips immediately
// - aux overcurrent when low-side drop exceeds threshold resistor drop
// - overcurrent shuts both regulators, tri-states drivers, pulls power-ok low
// - no automatic retry after overcurrent; only enable or supply toggle restarts
// - severe overvoltage latches power-ok low and turns on offending low-side switches
// - low-side clamp held until output below release level, then switches off
// - overvoltage clamp and release repeats without limit
// - overvoltage detection and clamp active whenever enabled, even after other faults
// - undervoltage latches after output low by margin for 205us continuously
// - undervoltage turns off both regulators' drivers and pulls power-ok low
`ifndef RAIL_FAULT_SUPERVISOR_PARAMS_SVH
`define RAIL_FAULT_SUPERVISOR_PARAMS_SVH

`define RFS_CLK_PERIOD_NS   40
`define RFS_OC_QUAL_NS      100000
`define RFS_UV_QUAL_NS      205000
// least times round up to whole cycles
`define RFS_OC_QUAL_CYC     ((`RFS_OC_QUAL_NS + `RFS_CLK_PERIOD_NS - 1) / `RFS_CLK_PERIOD_NS)
`define RFS_UV_QUAL_CYC     ((`RFS_UV_QUAL_NS + `RFS_CLK_PERIOD_NS - 1) / `RFS_CLK_PERIOD_NS)
`define RFS_TIMER_W         13

`define RFS_OC_GAIN         5
`define RFS_OC_DIV          6
// short threshold 2.25 = 9/4
`define RFS_SC_NUM          9
`define RFS_SC_DEN          4

`define RFS_RAILS           2
`define RFS_RAIL_CORE       0
`define RFS_RAIL_AUX        1

`define RFS_ST_OFF          2'b00
`define RFS_ST_SOFT         2'b01
`define RFS_ST_RUN          2'b11
`define RFS_ST_LATCHED      2'b10

`endif

// ---- hw/rail_fault_pkg.sv ----
// types shared by the rail fault supervisor
// assumes rail_fault_supervisor_params.svh is on the include path
`include "rail_fault_supervisor_params.svh"

package rail_fault_pkg;

    typedef enum logic [1:0] {
        ST_OFF     = `RFS_ST_OFF,
        ST_SOFT    = `RFS_ST_SOFT,
        ST_RUN     = `RFS_ST_RUN,
        ST_LATCHED = `RFS_ST_LATCHED
    } sup_state_type;

    // per-rail voltage comparator results
    typedef struct packed {
        logic over_volt;     // above severe overvoltage level
        logic ov_release;    // below clamp release level
        logic under_volt;    // below target by undervoltage margin
    } rail_cmp_type;

    // per-rail gate driver command
    typedef struct packed {
        logic tristate;      // both gates high impedance
        logic lowside_on;    // overvoltage clamp
        logic run;           // regulator may switch
    } rail_drive_type;

    typedef struct packed {
        logic core_oc;
        logic core_short;
        logic aux_oc;
        logic over_volt;
        logic under_volt;
    } fault_flags_type;

endpackage

// ---- hw/rail_fault_supervisor.sv ----
// rail fault supervisor: qualifies rail faults, latches off, drives power-ok and gate commands
// assumes comparator bits and enable/por arrive asynchronously; current codes come from
// converters clocked by mclk
`timescale 1ns/1ps
`default_nettype none
`include "rail_fault_supervisor_params.svh"

module rail_fault_supervisor #(
    parameter int SENSE_W        = 8,
    parameter int THR_W          = 12,
    parameter int OC_QUAL_CYCLES = `RFS_OC_QUAL_CYC,
    parameter int UV_QUAL_CYCLES = `RFS_UV_QUAL_CYC
) (
    input  wire logic                                   mclk,
    input  wire logic                                   sys_rst,
    input  wire logic                                   enable_in,
    input  wire logic                                   supply_por_in,
    input  wire logic                                   soft_start_done_in,
    input  wire logic [SENSE_W-1:0]                     core_sense_code,
    input  wire logic [THR_W-1:0]                       core_overcurrent_threshold_input,
    input  wire logic [SENSE_W-1:0]                     aux_lowside_drop_code,
    input  wire logic [SENSE_W-1:0]                     aux_overcurrent_threshold_input,
    input  wire rail_fault_pkg::rail_cmp_type [`RFS_RAILS-1:0] rail_cmp_in,
    output logic                                        power_ok_flag_out,
    output logic                                        power_ok_flag_oe_n,
    output rail_fault_pkg::rail_drive_type [`RFS_RAILS-1:0] rail_drive,
    output logic                                        soft_start_go,
    output rail_fault_pkg::fault_flags_type             fault_flags,
    output logic                                        ov_latched
);

    localparam int PROD_W = SENSE_W + THR_W + 4;
    localparam logic [`RFS_TIMER_W-1:0] OC_MAX = `RFS_TIMER_W'(OC_QUAL_CYCLES);
    localparam logic [`RFS_TIMER_W-1:0] UV_MAX = `RFS_TIMER_W'(UV_QUAL_CYCLES);
    localparam logic [PROD_W-1:0] OC_SCALE = PROD_W'(`RFS_OC_GAIN * `RFS_OC_DIV);
    localparam logic [PROD_W-1:0] SC_SCALE = PROD_W'(`RFS_OC_GAIN * `RFS_OC_DIV * `RFS_SC_DEN);
    localparam logic [PROD_W-1:0] SC_NUM   = PROD_W'(`RFS_SC_NUM);

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic                                      en_meta_q;
    logic                                      en_q;
    logic                                      por_meta_q;
    logic                                      por_q;
    logic                                      ssd_meta_q;
    logic                                      ssd_q;
    rail_fault_pkg::rail_cmp_type [`RFS_RAILS-1:0] cmp_meta_q;
    rail_fault_pkg::rail_cmp_type [`RFS_RAILS-1:0] cmp_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            en_meta_q  <= 1'b0;
            en_q       <= 1'b0;
            por_meta_q <= 1'b1;
            por_q      <= 1'b1;
            ssd_meta_q <= 1'b0;
            ssd_q      <= 1'b0;
            cmp_meta_q <= '0;
            cmp_q      <= '0;
        end else begin
            en_meta_q  <= enable_in;
            en_q       <= en_meta_q;
            por_meta_q <= supply_por_in;
            por_q      <= por_meta_q;
            ssd_meta_q <= soft_start_done_in;
            ssd_q      <= ssd_meta_q;
            cmp_meta_q <= rail_cmp_in;
            cmp_q      <= cmp_meta_q;
        end
    end

    // disabled by power-on reset or by enable low
    logic off_force;
    assign off_force = por_q | ~en_q;

    ////////////////////////////////////////////////////////////////////////////
    // overcurrent comparators, registered to break the multiply path

    logic core_oc_raw_q;
    logic core_sc_raw_q;
    logic aux_oc_raw_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            core_oc_raw_q <= 1'b0;
            core_sc_raw_q <= 1'b0;
            aux_oc_raw_q  <= 1'b0;
        end else begin
            // sense*5 > thr/6 rearranged to avoid the division
            core_oc_raw_q <= (PROD_W'(core_sense_code) * OC_SCALE)
                             > PROD_W'(core_overcurrent_threshold_input);
            core_sc_raw_q <= (PROD_W'(core_sense_code) * SC_SCALE)
                             > (PROD_W'(core_overcurrent_threshold_input) * SC_NUM);
            aux_oc_raw_q  <= aux_lowside_drop_code > aux_overcurrent_threshold_input;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // persistence timers

    logic [`RFS_TIMER_W-1:0] oc_cnt_q;
    logic                    oc_qual;

    always_ff @(posedge mclk) begin
        if (sys_rst || !core_oc_raw_q) begin
            oc_cnt_q <= '0;
        end else if (oc_cnt_q != OC_MAX) begin
            oc_cnt_q <= oc_cnt_q + `RFS_TIMER_W'(1);
        end
    end
    assign oc_qual = oc_cnt_q == OC_MAX;

    logic [`RFS_RAILS-1:0] uv_qual;
    logic [`RFS_RAILS-1:0] clamp_q;

    genvar gi;
    generate
        for (gi = 0; gi < `RFS_RAILS; gi++) begin : g_rail
            logic [`RFS_TIMER_W-1:0] uv_cnt_q;

            always_ff @(posedge mclk) begin
                if (sys_rst || !cmp_q[gi].under_volt) begin
                    uv_cnt_q <= '0;
                end else if (uv_cnt_q != UV_MAX) begin
                    uv_cnt_q <= uv_cnt_q + `RFS_TIMER_W'(1);
                end
            end
            assign uv_qual[gi] = uv_cnt_q == UV_MAX;

            // clamp re-arms each time the rail climbs back over the limit
            always_ff @(posedge mclk) begin
                if (sys_rst || off_force) begin
                    clamp_q[gi] <= 1'b0;
                end else if (cmp_q[gi].over_volt) begin
                    clamp_q[gi] <= 1'b1;
                end else if (cmp_q[gi].ov_release) begin
                    clamp_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // fault detection and latching

    rail_fault_pkg::sup_state_type state_q;
    logic                          regulating;
    logic                          ov_now;
    logic                          trip_oc;
    logic                          trip_uv;
    logic                          trip;

    assign regulating = (state_q == rail_fault_pkg::ST_SOFT) || (state_q == rail_fault_pkg::ST_RUN);
    assign ov_now     = cmp_q[`RFS_RAIL_CORE].over_volt | cmp_q[`RFS_RAIL_AUX].over_volt;
    assign trip_oc    = regulating & (oc_qual | core_sc_raw_q | aux_oc_raw_q);
    // soft-start ramps from zero, so undervoltage is judged only once running
    assign trip_uv    = (state_q == rail_fault_pkg::ST_RUN) & (|uv_qual);
    assign trip       = trip_oc | trip_uv | ov_now;

    rail_fault_pkg::fault_flags_type flags_q;
    logic                            ov_latch_q;

    always_ff @(posedge mclk) begin
        if (sys_rst || off_force) begin
            flags_q <= '0;
        end else begin
            // flags only set while enabled, so setting never races the clear
            flags_q.core_oc    <= flags_q.core_oc    | (regulating & oc_qual);
            flags_q.core_short <= flags_q.core_short | (regulating & core_sc_raw_q);
            flags_q.aux_oc     <= flags_q.aux_oc     | (regulating & aux_oc_raw_q);
            flags_q.over_volt  <= flags_q.over_volt  | ov_now;
            flags_q.under_volt <= flags_q.under_volt | trip_uv;
        end
    end

    // only a supply drop clears this; enable toggling leaves it set
    always_ff @(posedge mclk) begin
        if (sys_rst || por_q) begin
            ov_latch_q <= 1'b0;
        end else if (en_q && ov_now) begin
            ov_latch_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencing state machine

    always_ff @(posedge mclk) begin
        if (sys_rst || off_force) begin
            state_q <= rail_fault_pkg::ST_OFF;
        end else begin
            case (state_q)
                rail_fault_pkg::ST_OFF: begin
                    if (!ov_latch_q && !ov_now) begin
                        state_q <= rail_fault_pkg::ST_SOFT;
                    end
                end
                rail_fault_pkg::ST_SOFT: begin
                    if (trip) begin
                        state_q <= rail_fault_pkg::ST_LATCHED;
                    end else if (ssd_q) begin
                        state_q <= rail_fault_pkg::ST_RUN;
                    end
                end
                rail_fault_pkg::ST_RUN: begin
                    if (trip) begin
                        state_q <= rail_fault_pkg::ST_LATCHED;
                    end
                end
                rail_fault_pkg::ST_LATCHED: begin
                    state_q <= rail_fault_pkg::ST_LATCHED;
                end
                default: begin
                    state_q <= rail_fault_pkg::ST_OFF;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    logic pg_oe_n_q;
    logic pg_out_q;
    logic ss_go_q;
    rail_fault_pkg::rail_drive_type [`RFS_RAILS-1:0] drive_q;

    // open drain: pin value is always low, enable decides pull-down
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pg_out_q  <= 1'b0;
            pg_oe_n_q <= 1'b0;
        end else begin
            pg_out_q  <= 1'b0;
            // single indicator for both rails
            pg_oe_n_q <= (state_q == rail_fault_pkg::ST_RUN) && !trip && !ov_latch_q
                         && !(|clamp_q) && !off_force;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ss_go_q <= 1'b0;
        end else begin
            ss_go_q <= (state_q == rail_fault_pkg::ST_SOFT) && !trip && !off_force;
        end
    end

    // clamp beats everything; drivers switch only while sequencing and fault free
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            for (int i = 0; i < `RFS_RAILS; i++) begin
                drive_q[i].tristate   <= 1'b1;
                drive_q[i].lowside_on <= 1'b0;
                drive_q[i].run        <= 1'b0;
            end
        end else begin
            for (int i = 0; i < `RFS_RAILS; i++) begin
                drive_q[i].lowside_on <= clamp_q[i];
                drive_q[i].run        <= regulating && !trip && !off_force && !(|clamp_q);
                drive_q[i].tristate   <= !clamp_q[i]
                                         && !(regulating && !trip && !off_force && !(|clamp_q));
            end
        end
    end

    assign power_ok_flag_out  = pg_out_q;
    assign power_ok_flag_oe_n = pg_oe_n_q;
    assign rail_drive         = drive_q;
    assign soft_start_go      = ss_go_q;
    assign fault_flags        = flags_q;
    assign ov_latched         = ov_latch_q;

endmodule // rail_fault_supervisor

`default_nettype wire

// ---- bench/rail_fault_supervisor_properties.sv ----
// port-level timing properties of the rail fault supervisor
// assumes a bind onto the top module with both qualification counts handed on
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
module rail_fault_supervisor_properties #(
    parameter int OC_QUAL_CYCLES = 2500,
    parameter int UV_QUAL_CYCLES = 5125
) (
    input wire logic                                 mclk,
    input wire logic                                 sys_rst,
    input wire logic                                 enable_in,
    input wire logic [7:0]                           core_sense_code,
    input wire logic [11:0]                          core_overcurrent_threshold_input,
    input wire rail_fault_pkg::rail_cmp_type [1:0]   rail_cmp_in,
    input wire logic                                 power_ok_flag_oe_n,
    input wire rail_fault_pkg::rail_drive_type [1:0] rail_drive,
    input wire logic                                 soft_start_go,
    input wire rail_fault_pkg::fault_flags_type      fault_flags,
    input wire logic                                 ov_latched
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // run lengths of the raw conditions; bounds allow for sync and register lag
    logic [15:0] oc_run_q;
    logic [15:0] uv_run_q;
    wire logic   oc_raw = 16'(core_sense_code) * 16'h001e > 16'(core_overcurrent_threshold_input);
    wire logic   uv_raw = rail_cmp_in[0].under_volt | rail_cmp_in[1].under_volt;
    always_ff @(posedge mclk) begin
        if (sys_rst || !oc_raw) oc_run_q <= 16'h0000;
        else oc_run_q <= oc_run_q + 16'h0001;
    end
    always_ff @(posedge mclk) begin
        if (sys_rst || !uv_raw) uv_run_q <= 16'h0000;
        else uv_run_q <= uv_run_q + 16'h0001;
    end
    ////////////////////////////////////////
    AST_PG_OFF: assert property ((!enable_in) [*5] |-> !power_ok_flag_oe_n)
        else $error("power ok released while disabled");
    AST_PG_RELEASE: assert property ($rose(power_ok_flag_oe_n) |->
        !soft_start_go && fault_flags == 5'h00 && !ov_latched)
        else $error("power ok released before a clean start");
    AST_FAULT_PG: assert property ((fault_flags != 5'h00) [*3] |-> !power_ok_flag_oe_n)
        else $error("power ok high while latched");
    AST_SHUTDOWN: assert property ((fault_flags[4:2] != 3'h0 || fault_flags.under_volt) [*3]
        |-> !rail_drive[0].run && !rail_drive[1].run)
        else $error("regulator still running after fault");
    AST_OC_QUAL: assert property ($rose(fault_flags.core_oc)
        |-> $past(oc_run_q, 2) >= OC_QUAL_CYCLES - 2)
        else $error("overcurrent acted on too early");
    AST_UV_QUAL: assert property ($rose(fault_flags.under_volt)
        |-> $past(uv_run_q, 3) >= UV_QUAL_CYCLES - 3)
        else $error("undervoltage latched too early");
    AST_OV_CLAMP: assert property (rail_cmp_in[1].over_volt [*5]
        |-> rail_drive[1].lowside_on && !power_ok_flag_oe_n && ov_latched)
        else $error("overvoltage clamp missing");
    AST_OV_RELEASE: assert property ((rail_cmp_in[1].ov_release && !rail_cmp_in[1].over_volt) [*5]
        |-> !rail_drive[1].lowside_on)
        else $error("clamp held past release");
    AST_NO_RETRY: assert property ((fault_flags.core_oc || fault_flags.aux_oc) && enable_in
        |=> !soft_start_go)
        else $error("restart after overcurrent");
    AST_OV_LOCK: assert property (ov_latched [*2] |-> !soft_start_go)
        else $error("restart while overvoltage latched");
endmodule // rail_fault_supervisor_properties
`default_nettype wire

// ---- bench/power_ok_monitor.sv ----
// system monitor side of the shared power ok line
// assumes an external pull-up; the supervisor only ever pulls the line low
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
module power_ok_monitor (
    input  wire logic power_ok_flag_out,
    input  wire logic power_ok_flag_oe_n,
    output logic      power_ok_line
);
    // a released pin floats up through the resistor, never keeps its last value
    assign power_ok_line = power_ok_flag_oe_n ? 1'b1 : power_ok_flag_out;
endmodule // power_ok_monitor
`default_nettype wire

// ---- bench/tb_rail_fault_supervisor.sv ----
// self-checking bench for the rail fault supervisor
// assumes package, params header, monitor and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
module tb_rail_fault_supervisor;
    localparam int OC_Q = 10;
    localparam int UV_Q = 20;
    typedef struct packed {
        logic [7:0]  sense;
        logic [11:0] thr;
        logic [7:0]  drop;
        logic [5:0]  cmp;
        logic [4:0]  flags;
    } row_type;
    // cmp 6'h12: both rails in range; last row sits exactly on both thresholds
    row_type rows [6] = '{
        '{8'h10, 12'h0100, 8'h10, 6'h12, 5'h10},
        '{8'h40, 12'h0100, 8'h10, 6'h12, 5'h08},
        '{8'h01, 12'h0100, 8'h21, 6'h12, 5'h04},
        '{8'h01, 12'h0100, 8'h10, 6'h13, 5'h01},
        '{8'h01, 12'h0100, 8'h10, 6'h1a, 5'h01},
        '{8'h10, 12'h01e0, 8'h20, 6'h12, 5'h00}};
    logic                                 mclk = 1'b0;
    logic                                 sys_rst = 1'b1;
    logic                                 enable_in = 1'b0;
    logic                                 supply_por_in = 1'b0;
    logic                                 soft_start_done_in = 1'b0;
    logic [7:0]                           core_sense_code = 8'h01;
    logic [11:0]                          core_overcurrent_threshold_input = 12'h0100;
    logic [7:0]                           aux_lowside_drop_code = 8'h10;
    logic [7:0]                           aux_overcurrent_threshold_input = 8'h20;
    rail_fault_pkg::rail_cmp_type [1:0]   rail_cmp_in = 6'h12;
    rail_fault_pkg::rail_drive_type [1:0] rail_drive;
    rail_fault_pkg::fault_flags_type      fault_flags;
    logic                                 power_ok_flag_out;
    logic                                 power_ok_flag_oe_n;
    logic                                 soft_start_go;
    logic                                 ov_latched;
    logic                                 power_ok_line;
    int                                   err_count = 0;
    int                                   checks_done = 0;
    int                                   n;

    rail_fault_supervisor #(.OC_QUAL_CYCLES(OC_Q), .UV_QUAL_CYCLES(UV_Q)) dut_u (.*);
    power_ok_monitor mon_u (.*);

    initial begin
        forever #20 mclk = ~mclk;
    end
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // host side: an enable toggle clears a latched fault other than overvoltage, which only a supply drop clears
    task automatic bring_up();
        @(posedge mclk) enable_in <= 1'b0;
        soft_start_done_in <= 1'b0;
        repeat (8) @(negedge mclk);
        chk("power ok off", 8'h00, 8'(power_ok_line));
        chk("flags cleared", 8'h00, 8'(fault_flags));
        @(posedge mclk) enable_in <= 1'b1;
        repeat (15) @(negedge mclk);
        chk("soft start", 8'h01, 8'(soft_start_go));
        chk("power ok soft", 8'h00, 8'(power_ok_line));
        @(posedge mclk) soft_start_done_in <= 1'b1;
        for (n = 0; n < 40 && power_ok_line !== 1'b1; n++) @(negedge mclk);
        chk("power ok run", 8'h01, 8'(power_ok_line));
    endtask

    task automatic run_row(input row_type r);
        bring_up();
        @(posedge mclk) core_sense_code <= r.sense;
        core_overcurrent_threshold_input <= r.thr;
        aux_lowside_drop_code <= r.drop;
        rail_cmp_in <= r.cmp;
        for (n = 0; n < 60 && fault_flags === 5'h00; n++) @(negedge mclk);
        chk("fault flags", 8'(r.flags), 8'(fault_flags));
        if (r.flags[4]) chk("oc qualified", 8'h01, 8'(n >= OC_Q));
        if (r.flags[3]) chk("short immediate", 8'h01, 8'(n < OC_Q));
        repeat (3) @(negedge mclk);
        chk("power ok", 8'(r.flags == 5'h00), 8'(power_ok_line));
        chk("drivers", (r.flags == 5'h00) ? 8'h03 : 8'h0c, {4'h0, rail_drive[0].tristate,
            rail_drive[1].tristate, rail_drive[0].run, rail_drive[1].run});
        @(posedge mclk) core_sense_code <= 8'h01;
        core_overcurrent_threshold_input <= 12'h0100;
        aux_lowside_drop_code <= 8'h10;
        rail_cmp_in <= 6'h12;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            run_row(rows[i]);
            $display("row %0d done", i);
        end
        // two short bursts, each under the qualification time
        bring_up();
        repeat (2) begin
            @(posedge mclk) core_sense_code <= 8'h10;
            repeat (OC_Q - 4) @(posedge mclk);
            core_sense_code <= 8'h01;
        end
        repeat (OC_Q) @(negedge mclk);
        chk("burst ignored", 8'h00, 8'(fault_flags));
        @(posedge mclk) sys_rst <= 1'b1;
        repeat (2) @(negedge mclk);
        chk("reset power ok", 8'h00, 8'(power_ok_line));
        chk("reset start", 8'h00, 8'(soft_start_go));
        @(posedge mclk) sys_rst <= 1'b0;
        $display("test burst and reset done");
        // second pass clamps while already latched off
        bring_up();
        repeat (2) begin
            @(posedge mclk) rail_cmp_in[1] <= 3'h4;
            for (n = 0; n < 20 && rail_drive[1].lowside_on !== 1'b1; n++) @(negedge mclk);
            chk("clamp", 8'h15, {3'h0, fault_flags.over_volt,
                rail_drive[0].lowside_on, rail_drive[1].lowside_on, power_ok_line, ov_latched});
            @(posedge mclk) rail_cmp_in[1] <= 3'h2;
            for (n = 0; n < 20 && rail_drive[1].lowside_on !== 1'b0; n++) @(negedge mclk);
            chk("unclamp", 8'h00, 8'(rail_drive[1].lowside_on));
        end
        @(posedge mclk) enable_in <= 1'b0;
        repeat (8) @(posedge mclk);
        enable_in <= 1'b1;
        repeat (20) @(negedge mclk);
        chk("no restart on enable", 8'h00, {6'h00, soft_start_go, power_ok_line});
        @(posedge mclk) supply_por_in <= 1'b1;
        repeat (8) @(posedge mclk);
        supply_por_in <= 1'b0;
        for (n = 0; n < 20 && soft_start_go !== 1'b1; n++) @(negedge mclk);
        chk("restart after por", 8'h02, {6'h00, soft_start_go, ov_latched});
        $display("test overvoltage done");
        report_and_stop();
    end

    // about 500 cycles expected
    initial begin
        repeat (4000) @(posedge mclk);
        err_count++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule // tb_rail_fault_supervisor

bind rail_fault_supervisor rail_fault_supervisor_properties #(
    .OC_QUAL_CYCLES(OC_QUAL_CYCLES), .UV_QUAL_CYCLES(UV_QUAL_CYCLES)) chk_u (.*);
`default_nettype wire
